// ---- include/iom_regs.svh ----
// register offsets, image indexes and field positions of the image mapper
// assumes a 32-bit apb slave with one aligned word per register
`ifndef IOM_REGS_SVH
`define IOM_REGS_SVH

// byte address regions
`define IOM_IN_BASE 2'b00
`define IOM_OUT_BASE 2'b01
`define IOM_CFG_BASE 2'b10
// configuration and status registers inside the cfg region (word index)
`define IOM_AICTRL_LO 4'h0
`define IOM_AICTRL_HI 4'h1
`define IOM_AISTAT_LO 4'h2
`define IOM_AISTAT_HI 4'h3
`define IOM_MODE_STAT 4'h4
// input image word counts per field-module layout
`define IOM_IN_WORDS_PLAIN 4'h7
`define IOM_IN_WORDS_MBX 4'hb
// input image word indexes
`define IOM_IW_AI1_MEAS 0
`define IOM_IW_AI1_REF 1
`define IOM_IW_AI2_CH1 2
`define IOM_IW_AI2_CH2 3
`define IOM_IW_FP_BASE 4
`define IOM_IW_DI_PLAIN 6
`define IOM_IW_MBX_STAT 4
`define IOM_IW_MBX_RESP 5
`define IOM_IW_MBX_CH1 8
`define IOM_IW_MBX_CH2 9
`define IOM_IW_DI_MBX 10
// output image word indexes
`define IOM_OW_DO16_PLAIN 4'h0
`define IOM_OW_DIO_PLAIN 4'h1
`define IOM_OW_MBX_UNUSED0 4'h4
`define IOM_OW_MBX_UNUSED1 4'h5
`define IOM_OW_DO16_MBX 4'h6
`define IOM_OW_DIO_MBX 4'h7
// widths
`define IOM_AI_CHANNELS 5
`define IOM_PIN_WIDTH 201
// reset values
`define IOM_RST_BYTE 8'h00
`define IOM_RST_WORD 16'h0000

`endif

// ---- include/iom_pkg.sv ----
// types shared by the image mapper modules
// assumes iom_regs.svh is on the include path
package iom_pkg;
   typedef logic [15:0] iom_word_t;
   typedef logic [10:0][15:0] iom_in_img_t;
   typedef enum logic [2:0] {
      OS_CTRL = 3'b000,
      OS_REQ0 = 3'b001,
      OS_REQ1 = 3'b010,
      OS_REQ2 = 3'b011,
      OS_UNUSED = 3'b100,
      OS_DO16 = 3'b101,
      OS_DIO = 3'b110,
      OS_NONE = 3'b111
   } iom_out_slot_e;
endpackage

// ---- include/iom_img_if.sv ----
// bundle between the top and the input image packer
// assumes all sources are already in the CLOCK domain
`timescale 1ns/1ps
interface iom_img_if;
   import iom_pkg::*;
   logic clk;
   logic rst_n;
   logic mailbox_mode;
   iom_word_t ai1_meas;
   iom_word_t ai1_ref;
   iom_word_t ai2_ch1;
   iom_word_t ai2_ch2;
   iom_word_t fp_ch1;
   iom_word_t fp_ch2;
   logic [7:0] module_status_byte;
   logic [47:0] mailbox_response_byte;
   logic [7:0] input_channel_bit;
   iom_in_img_t img;
   modport src (output clk, rst_n, mailbox_mode, ai1_meas, ai1_ref, ai2_ch1,
      ai2_ch2, fp_ch1, fp_ch2, module_status_byte, mailbox_response_byte,
      input_channel_bit, input img);
   modport packer (input clk, rst_n, mailbox_mode, ai1_meas, ai1_ref,
      ai2_ch1, ai2_ch2, fp_ch1, fp_ch2, module_status_byte,
      mailbox_response_byte, input_channel_bit, output img);
endinterface

// ---- rtl/iom_in_packer.sv ----
// packs analog words, field-module words and digital inputs into the
// input image; assumes synchronised sources from the top
`timescale 1ns/1ps
`include "iom_regs.svh"
module iom_in_packer
   import iom_pkg::*;
(
   // image sources and result
   iom_img_if.packer bus
);
   wire mbx = bus.mailbox_mode;
   wire [15:0] di_word = {8'h00, bus.input_channel_bit};
   wire [15:0] stat_word = {8'h00, bus.module_status_byte};

   // analog words come first, digital byte last
   assign bus.img[`IOM_IW_AI1_MEAS] = bus.ai1_meas;
   assign bus.img[`IOM_IW_AI1_REF] = bus.ai1_ref;
   assign bus.img[`IOM_IW_AI2_CH1] = bus.ai2_ch1;
   assign bus.img[`IOM_IW_AI2_CH2] = bus.ai2_ch2;
   // field module: two plain words or status, mailbox, values
   assign bus.img[4] = mbx ? stat_word : bus.fp_ch1;
   assign bus.img[5] = mbx ? bus.mailbox_response_byte[15:0]
                           : bus.fp_ch2;
   assign bus.img[6] = mbx ? bus.mailbox_response_byte[31:16]
                           : di_word;
   assign bus.img[7] = mbx ? bus.mailbox_response_byte[47:32]
                           : `IOM_RST_WORD;
   assign bus.img[`IOM_IW_MBX_CH1] = mbx ? bus.fp_ch1 : `IOM_RST_WORD;
   assign bus.img[`IOM_IW_MBX_CH2] = mbx ? bus.fp_ch2 : `IOM_RST_WORD;
   assign bus.img[`IOM_IW_DI_MBX] = mbx ? di_word : `IOM_RST_WORD;

   a_single_layout: assert property (@(posedge bus.clk)
      disable iff (!bus.rst_n)
      bus.img[0] == bus.ai1_meas && bus.img[1] == bus.ai1_ref)
      else $error("single channel words misplaced");
   a_plain_layout: assert property (@(posedge bus.clk)
      disable iff (!bus.rst_n)
      !mbx |-> bus.img[4] == bus.fp_ch1 && bus.img[5] == bus.fp_ch2
      && bus.img[6][7:0] == bus.input_channel_bit)
      else $error("plain field layout wrong");
   a_mbx_layout: assert property (@(posedge bus.clk)
      disable iff (!bus.rst_n)
      mbx |-> bus.img[4][7:0] == bus.module_status_byte
      && {bus.img[7], bus.img[6], bus.img[5]} == bus.mailbox_response_byte
      && bus.img[8] == bus.fp_ch1 && bus.img[9] == bus.fp_ch2)
      else $error("mailbox layout wrong");
   a_reserved_zero: assert property (@(posedge bus.clk)
      disable iff (!bus.rst_n)
      mbx ? bus.img[4][15:8] == 8'h00
            && bus.img[`IOM_IW_DI_MBX][15:8] == 8'h00
          : bus.img[`IOM_IW_DI_PLAIN][15:8] == 8'h00
            && bus.img[7] == 16'h0000)
      else $error("reserved input bits not zero");
endmodule

// ---- rtl/iom_mapper_top.sv ----
// process image mapper: apb slave holding input and output images
// assumes an apb3 master on CLOCK and asynchronous module pins
`timescale 1ns/1ps
`include "iom_regs.svh"
module iom_mapper_top
   import iom_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // analog input values
   input wire logic [15:0] AI_SINGLE_MEAS,
   input wire logic [15:0] AI_SINGLE_REF,
   input wire logic [15:0] AI_DUAL_CH1,
   input wire logic [15:0] AI_DUAL_CH2,
   input wire logic [15:0] FP_CH1,
   input wire logic [15:0] FP_CH2,
   // analog per-channel control and status
   input wire logic [39:0] AI_STATUS,
   output logic [39:0] AI_CONTROL,
   // field-protocol module mailbox
   input wire logic FP_MAILBOX_MODE,
   input wire logic [7:0] FP_MODULE_STATUS_BYTE,
   input wire logic [47:0] FP_MAILBOX_RESPONSE_BYTE,
   output logic [7:0] FP_MODULE_CONTROL_BYTE,
   output logic [47:0] FP_MAILBOX_REQUEST_BYTE,
   // digital modules
   input wire logic [7:0] INPUT_CHANNEL_BIT,
   output logic [15:0] DO16_CHANNEL,
   output logic [7:0] DIO_OUT_CHANNEL
);
   iom_img_if img_bus ();

   // output image slot for a word index under the current layout
   function automatic iom_out_slot_e out_slot(input logic [3:0] idx,
                                              input logic mbx);
      iom_out_slot_e s;
      s = OS_NONE;
      if (mbx) begin
         case (idx)
            4'h0: s = OS_CTRL;
            4'h1: s = OS_REQ0;
            4'h2: s = OS_REQ1;
            4'h3: s = OS_REQ2;
            `IOM_OW_MBX_UNUSED0: s = OS_UNUSED;
            `IOM_OW_MBX_UNUSED1: s = OS_UNUSED;
            `IOM_OW_DO16_MBX: s = OS_DO16;
            `IOM_OW_DIO_MBX: s = OS_DIO;
            default: s = OS_NONE;
         endcase
      end else begin
         case (idx)
            `IOM_OW_DO16_PLAIN: s = OS_DO16;
            `IOM_OW_DIO_PLAIN: s = OS_DIO;
            default: s = OS_NONE;
         endcase
      end
      return s;
   endfunction

   // two-stage synchroniser for every pin input
   logic [`IOM_PIN_WIDTH-1:0] pin_meta;
   logic [`IOM_PIN_WIDTH-1:0] pin_sync;
   wire [`IOM_PIN_WIDTH-1:0] pin_raw = {AI_SINGLE_MEAS, AI_SINGLE_REF,
      AI_DUAL_CH1, AI_DUAL_CH2, FP_CH1, FP_CH2, AI_STATUS, FP_MAILBOX_MODE,
      FP_MODULE_STATUS_BYTE, FP_MAILBOX_RESPONSE_BYTE, INPUT_CHANNEL_BIT};

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   // synchronised pins unpacked into the packer bundle
   wire [39:0] ai_status_s = pin_sync[104:65];
   wire mbx = pin_sync[64];
   assign img_bus.clk = CLOCK;
   assign img_bus.rst_n = RST_N;
   assign img_bus.ai1_meas = pin_sync[200:185];
   assign img_bus.ai1_ref = pin_sync[184:169];
   assign img_bus.ai2_ch1 = pin_sync[168:153];
   assign img_bus.ai2_ch2 = pin_sync[152:137];
   assign img_bus.fp_ch1 = pin_sync[136:121];
   assign img_bus.fp_ch2 = pin_sync[120:105];
   assign img_bus.mailbox_mode = mbx;
   assign img_bus.module_status_byte = pin_sync[63:56];
   assign img_bus.mailbox_response_byte = pin_sync[55:8];
   assign img_bus.input_channel_bit = pin_sync[7:0];

   iom_in_packer u_packer (
      .bus (img_bus)
   );

   // address decode
   wire [3:0] idx = PADDR[5:2];
   wire aligned = PADDR[1:0] == 2'b00;
   wire in_reg = aligned && PADDR[7:6] == `IOM_IN_BASE;
   wire out_reg = aligned && PADDR[7:6] == `IOM_OUT_BASE;
   wire cfg_reg = aligned && PADDR[7:6] == `IOM_CFG_BASE;
   wire [3:0] in_words = mbx ? `IOM_IN_WORDS_MBX : `IOM_IN_WORDS_PLAIN;
   wire in_hit = in_reg && idx < in_words;
   wire iom_out_slot_e slot = out_reg ? out_slot(idx, mbx) : OS_NONE;
   wire out_hit = slot != OS_NONE;
   wire cfg_hit = cfg_reg && idx <= `IOM_MODE_STAT;
   wire cfg_wr_ok = idx == `IOM_AICTRL_LO || idx == `IOM_AICTRL_HI;
   wire next_err = !(out_hit || (in_hit && !PWRITE)
      || (cfg_hit && (!PWRITE || cfg_wr_ok)));

   // registers that hold the output image and channel configuration
   logic [7:0] ctrl_byte;
   logic [47:0] req;
   logic [15:0] do16;
   logic [7:0] dio_out;
   logic [39:0] ai_ctrl;

   // read data selection
   wire [15:0] in_word = img_bus.img[idx];
   wire [31:0] out_rd =
      slot == OS_CTRL ? {24'h000000, ctrl_byte} :
      slot == OS_REQ0 ? {16'h0000, req[15:0]} :
      slot == OS_REQ1 ? {16'h0000, req[31:16]} :
      slot == OS_REQ2 ? {16'h0000, req[47:32]} :
      slot == OS_DO16 ? {16'h0000, do16} :
      slot == OS_DIO ? {24'h000000, dio_out} : 32'h00000000;
   wire [31:0] cfg_rd =
      idx == `IOM_AICTRL_LO ? ai_ctrl[31:0] :
      idx == `IOM_AICTRL_HI ? {24'h000000, ai_ctrl[39:32]} :
      idx == `IOM_AISTAT_LO ? ai_status_s[31:0] :
      idx == `IOM_AISTAT_HI ? {24'h000000, ai_status_s[39:32]} :
      idx == `IOM_MODE_STAT ? {28'h0000000, in_words} : 32'h00000000;
   wire [31:0] next_rdata = next_err ? 32'h00000000 :
      in_reg ? {16'h0000, in_word} :
      out_reg ? out_rd : cfg_rd;

   // one wait state: pready rises the cycle after the access phase opens
   wire acc = PSEL && PENABLE;
   wire take = acc && !PREADY;
   wire wr_fire = acc && PREADY && PWRITE && !PSLVERR;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h00000000;
      end else begin
         PREADY <= take;
         PSLVERR <= take && next_err;
         PRDATA <= take ? next_rdata : 32'h00000000;
      end
   end

   // output image writes; unused slots and high bytes are dropped
   wire wr_ctrl = wr_fire && slot == OS_CTRL;
   wire wr_do16 = wr_fire && slot == OS_DO16;
   wire wr_dio = wr_fire && slot == OS_DIO;
   wire wr_ai_lo = wr_fire && cfg_reg && idx == `IOM_AICTRL_LO;
   wire wr_ai_hi = wr_fire && cfg_reg && idx == `IOM_AICTRL_HI;

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_byte <= `IOM_RST_BYTE;
         do16 <= `IOM_RST_WORD;
         dio_out <= `IOM_RST_BYTE;
      end else begin
         if (wr_ctrl) ctrl_byte <= PWDATA[7:0];
         if (wr_do16) do16 <= PWDATA[15:0];
         if (wr_dio) dio_out <= PWDATA[7:0];
      end
   end

   // mailbox request words, low byte first in each word
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_req
         always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
               req[16*g +: 16] <= `IOM_RST_WORD;
            end else if (wr_fire && slot == iom_out_slot_e'(g + 1)) begin
               req[16*g +: 16] <= PWDATA[15:0];
            end
         end
      end
   endgenerate

   // channel control bits are configuration only
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         ai_ctrl <= '0;
      end else begin
         if (wr_ai_lo) ai_ctrl[31:0] <= PWDATA;
         if (wr_ai_hi) ai_ctrl[39:32] <= PWDATA[7:0];
      end
   end

   assign DO16_CHANNEL = do16;
   assign DIO_OUT_CHANNEL = dio_out;
   assign FP_MODULE_CONTROL_BYTE = ctrl_byte;
   assign FP_MAILBOX_REQUEST_BYTE = req;
   assign AI_CONTROL = ai_ctrl;

   // assertions
   sequence s_access;
      PSEL && PENABLE && !PREADY;
   endsequence
   sequence s_done;
      PREADY ##1 !PREADY;
   endsequence
   sequence s_refused;
      PSEL && PENABLE && PREADY && PSLVERR;
   endsequence
   sequence s_cfg_read(logic [3:0] reg_idx);
      take && cfg_reg && !PWRITE && idx == reg_idx;
   endsequence

   // apb handshake and synchroniser
   a_apb_answer: assert property (@(posedge CLOCK) disable iff (!RST_N)
      s_access |=> s_done)
      else $error("apb answer not after one wait state");
   a_err_pulse: assert property (@(posedge CLOCK) disable iff (!RST_N)
      PSLVERR |-> PREADY)
      else $error("error flag without ready");
   a_rdata_idle: assert property (@(posedge CLOCK) disable iff (!RST_N)
      !PREADY |-> PRDATA == 32'h00000000)
      else $error("read data not zero outside the answer");
   a_refused_write: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      s_refused |=> $stable(DO16_CHANNEL) && $stable(DIO_OUT_CHANNEL)
      && $stable(AI_CONTROL) && $stable(FP_MODULE_CONTROL_BYTE)
      && $stable(FP_MAILBOX_REQUEST_BYTE))
      else $error("refused access changed an output");
   a_sync_stages: assert property (@(posedge CLOCK) disable iff (!RST_N)
      $past(RST_N) && $past(RST_N, 2) |-> pin_sync == $past(pin_raw, 2))
      else $error("pin inputs not two stages late");

   // output image
   a_do16_write: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      wr_do16 |=> DO16_CHANNEL[7:0] == $past(PWDATA[7:0])
      && DO16_CHANNEL[15:8] == $past(PWDATA[15:8]))
      else $error("sixteen-channel byte mapping wrong");
   a_do16_hold: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      !wr_do16 |=> $stable(DO16_CHANNEL))
      else $error("sixteen-channel outputs moved without a write");
   a_dio_loop: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      wr_dio |=> DIO_OUT_CHANNEL == $past(PWDATA[7:0]))
      else $error("combo output byte not driven");
   a_dio_hold: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      !wr_dio |=> $stable(DIO_OUT_CHANNEL))
      else $error("combo outputs moved without a write");
   a_ctrl_write: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      wr_ctrl |=> FP_MODULE_CONTROL_BYTE == $past(PWDATA[7:0]))
      else $error("control byte not stored");
   a_mbx_request: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      wr_fire && mbx && out_reg && idx == 4'h1
      |=> FP_MAILBOX_REQUEST_BYTE[15:0] == $past(PWDATA[15:0]))
      else $error("mailbox request word not stored");
   a_req_mid: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      wr_fire && slot == OS_REQ1
      |=> FP_MAILBOX_REQUEST_BYTE[31:16] == $past(PWDATA[15:0]))
      else $error("second request word not stored");
   a_req_last: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      wr_fire && slot == OS_REQ2
      |=> FP_MAILBOX_REQUEST_BYTE[47:32] == $past(PWDATA[15:0]))
      else $error("third request word not stored");
   a_plain_no_mbx: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      wr_fire && !mbx |=> $stable(FP_MAILBOX_REQUEST_BYTE)
      && $stable(FP_MODULE_CONTROL_BYTE))
      else $error("plain layout reached the mailbox");
   a_unused_ignored: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      wr_fire && slot == OS_UNUSED |=> $stable(FP_MAILBOX_REQUEST_BYTE)
      && $stable(DO16_CHANNEL) && $stable(FP_MODULE_CONTROL_BYTE))
      else $error("unused output word changed state");

   // input image and configuration
   a_in_read_le: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      take && in_hit && !PWRITE && idx == 4'h0
      |=> PRDATA == {16'h0000, $past(img_bus.ai1_meas)})
      else $error("input word not little endian value");
   a_ctrl_hidden: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      wr_ai_lo |=> AI_CONTROL[31:0] == $past(PWDATA)
      && (!$stable(pin_sync) || $stable(img_bus.img)))
      else $error("control bits reached the input image");
   a_ai_ctrl_hi: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      wr_ai_hi |=> AI_CONTROL[39:32] == $past(PWDATA[7:0]))
      else $error("upper channel control bits not stored");
   a_status_read: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      s_cfg_read(`IOM_AISTAT_LO) |=> PRDATA == $past(ai_status_s[31:0]))
      else $error("channel status not readable");
   a_mode_stat: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      s_cfg_read(`IOM_MODE_STAT)
      |=> PRDATA == ($past(mbx) ? 32'h0000000b : 32'h00000007))
      else $error("image size register wrong for the mode");
   a_mode_words: assert property (@(posedge CLOCK)
      disable iff (!RST_N)
      take && in_reg && !PWRITE && idx == 4'ha
      |=> PSLVERR == !$past(mbx))
      else $error("mailbox image size wrong");
endmodule

// ---- dv/iom_ctrl_model.sv ----
// controller application model: apb master that reads and writes images
// assumes the bench calls xfer hierarchically, one transfer at a time
`timescale 1ns/1ps
module iom_ctrl_model (
   // clock
   input wire logic clk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // request held until pready is sampled high; no latency is assumed
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines show the inverse so stale values are never trusted
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// ---- dv/iom_mapper_top_tb.sv ----
// self-checking bench for the process image mapper
// assumes the controller model drives apb and the bench drives module pins
`timescale 1ns/1ps
module iom_mapper_top_tb;
   import iom_pkg::*;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel, penable, pwrite, ready, slverr, mode = 1'b0;
   logic [7:0] paddr, st = 8'h00, di = 8'h00, ctrl, dio;
   logic [31:0] pwdata, prdata, rd, seed = 32'h4c6e;
   logic [15:0] meas = 16'h0, refv = 16'h0, d1 = 16'h0, d2 = 16'h0;
   logic [15:0] f1 = 16'h0, f2 = 16'h0, do16;
   logic [39:0] ai_st = 40'h0, ai_ctl;
   logic [47:0] resp = 48'h0, req;
   logic [31:0] dat [8];
   logic err;
   int n_fail = 0;
   int samples_checked = 0;

   always #4 clk = ~clk;

   iom_mapper_top i_dut (.CLOCK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(ready), .PSLVERR(slverr),
      .AI_SINGLE_MEAS(meas), .AI_SINGLE_REF(refv), .AI_DUAL_CH1(d1),
      .AI_DUAL_CH2(d2), .FP_CH1(f1), .FP_CH2(f2), .AI_STATUS(ai_st),
      .AI_CONTROL(ai_ctl), .FP_MAILBOX_MODE(mode),
      .FP_MODULE_STATUS_BYTE(st), .FP_MAILBOX_RESPONSE_BYTE(resp),
      .FP_MODULE_CONTROL_BYTE(ctrl), .FP_MAILBOX_REQUEST_BYTE(req),
      .INPUT_CHANNEL_BIT(di), .DO16_CHANNEL(do16), .DIO_OUT_CHANNEL(dio));

   iom_ctrl_model i_ctrl (.clk(clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(ready), .pslverr(slverr));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] rnd();
      seed = lfsr(seed);
      return seed;
   endfunction

   // expected input word i for the current layout
   function automatic logic [31:0] exp_in(input int i);
      logic [15:0] w;
      w = 16'h0;
      case (i)
         0: w = meas;
         1: w = refv;
         2: w = d1;
         3: w = d2;
         default: w = 16'h0;
      endcase
      if (!mode && i == 4) w = f1;
      if (!mode && i == 5) w = f2;
      if (!mode && i == 6) w = {8'h00, di};
      if (mode && i == 4) w = {8'h00, st};
      if (mode && i >= 5 && i <= 7) w = resp[16*(i-5) +: 16];
      if (mode && i == 8) w = f1;
      if (mode && i == 9) w = f2;
      if (mode && i == 10) w = {8'h00, di};
      return {16'h0000, w};
   endfunction

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      #200000;
      n_fail++;
      conclude();
   end

   initial begin
      int nw;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      `CHK({do16, dio, ctrl, ready}, 33'h0)
      for (int r = 0; r < 6; r++) begin
         @(posedge clk);
         mode <= r[0];
         meas <= (r == 2) ? 16'hffff : 16'(rnd());
         {refv, d1} <= rnd();
         {d2, f1} <= rnd();
         {f2, st, di} <= rnd();
         resp <= 48'({rnd(), rnd()});
         ai_st <= 40'({rnd(), rnd()});
         repeat (3) @(posedge clk);
         nw = r[0] ? 11 : 7;
         i_ctrl.xfer(1'b0, 8'h90, 32'h0, rd, err);
         `CHK({err, rd}, {1'b0, 32'(nw)})
         for (int i = 0; i < nw; i++) begin
            i_ctrl.xfer(1'b0, 8'(4 * i), 32'h0, rd, err);
            `CHK(err, 1'b0)
            `CHK(rd, exp_in(i))
         end
         i_ctrl.xfer(1'b0, 8'(4 * nw), 32'h0, rd, err);
         `CHK(err, 1'b1)
         // output image: plain is DO16 then combo, mailbox puts six words ahead of them
         for (int j = 0; j < (r[0] ? 8 : 2); j++) begin
            dat[j] = rnd();
            i_ctrl.xfer(1'b1, 8'h40 + 8'(4 * j), dat[j], rd, err);
            `CHK(err, 1'b0)
         end
         @(posedge clk);
         if (r[0]) begin
            `CHK(ctrl, dat[0][7:0])
            `CHK(req, {dat[3][15:0], dat[2][15:0], dat[1][15:0]})
            `CHK({do16, dio}, {dat[6][15:0], dat[7][7:0]})
            i_ctrl.xfer(1'b0, 8'h54, 32'h0, rd, err);
            `CHK(rd, 32'h0)
         end else begin
            `CHK({do16, dio}, {dat[0][15:0], dat[1][7:0]})
         end
         // refused accesses change nothing
         i_ctrl.xfer(1'b1, 8'h42, 32'hffff_ffff, rd, err);
         `CHK(err, 1'b1)
         i_ctrl.xfer(1'b1, 8'h00, 32'hffff_ffff, rd, err);
         `CHK(err, 1'b1)
         i_ctrl.xfer(1'b0, 8'h98, 32'h0, rd, err);
         `CHK(err, 1'b1)
         @(posedge clk);
         `CHK(do16, dat[r[0] ? 6 : 0][15:0])
         // per-channel control and status stay in the cfg region
         dat[0] = rnd();
         i_ctrl.xfer(1'b1, 8'h80, dat[0], rd, err);
         i_ctrl.xfer(1'b1, 8'h84, dat[0] ^ 32'h5a, rd, err);
         @(posedge clk);
         `CHK(ai_ctl, {dat[0][7:0] ^ 8'h5a, dat[0]})
         i_ctrl.xfer(1'b0, 8'h88, 32'h0, rd, err);
         `CHK(rd, ai_st[31:0])
         i_ctrl.xfer(1'b0, 8'h8c, 32'h0, rd, err);
         `CHK(rd, {24'h0, ai_st[39:32]})
      end
      conclude();
   end
endmodule
